// ===== logic/cssr_map.svh
/*
 * constants of the clock source select and reset block: rates, timeout,
 * power-on defaults of the configuration word.
 * assumes inclusion by bare name from the selector module, its checker and the bench.
 */
`ifndef CSSR_MAP_SVH
`define CSSR_MAP_SVH

// system clock and nominal internal oscillator rate in Hz
`define CSSR_SYS_HZ        25'h17D_7840
`define CSSR_OSC_HZ        25'h0B7_1B00
// trim step of 4096 Hz per count of the otp trim field, given as a shift
`define CSSR_TRIM_SHIFT    12
// internal periods without an external edge before falling back
`define CSSR_EXT_TIMEOUT   6'h20
// power-on defaults, replaced by otp once it reports valid
`define CSSR_DEF_TRIM      8'h00
`define CSSR_DEF_PWRDN     8'h14
// power-down delay field counts units of 256 selected ticks, given as a shift
`define CSSR_PWRDN_SHIFT   8

`endif

// ===== logic/cssr_pkg.sv
/*
 * types shared by the clock source select block.
 * assumes cssr_map.svh is on the include path.
 */
package cssr_pkg;

    // configuration loaded at power-on, both fields from otp
    typedef struct packed {
        logic [7:0] trim;
        logic [7:0] pwrdn_delay;
    } cssr_cfg_type;

    // clock source state
    typedef enum logic [1:0] {
        CSSR_LOAD,
        CSSR_INT,
        CSSR_EXT
    } cssr_state_type;

    // status bundle of the selector
    typedef struct packed {
        logic ext_sel;
        logic cfg_ready;
        logic ext_fail;
    } cssr_status_type;

endpackage

// ===== logic/cssr_pin_sync.sv
/*
 * three-stage synchroniser for a pin from outside the clock domain.
 * a change counts once stages two and three agree; gives level and rise.
 * assumes the pin may toggle at any time relative to clk.
 */
`timescale 1ns/1ps
module cssr_pin_sync
    import cssr_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // asynchronous pin
    input  wire logic pin,
    // filtered result
    output logic      level_q,
    output logic      rise_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // raw chain; s1 feeds only s2 to keep metastability contained
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a new level only when the two later stages agree
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end
        else
        begin
            rise_q <= (s2_q == s3_q) && s3_q && !level_q;
            if (s2_q == s3_q)
            begin
                level_q <= s3_q;
            end
        end
    end

endmodule

// ===== logic/cssr_clock_select.sv
/*
 * clock source select and power-on configuration for a stepper driver core.
 * holds the modelled internal oscillator, the external clock detector with
 * its timeout, and the selected time base that paces all timed functions.
 * assumes clk is a 25 MHz system clock; the external clock arrives on an
 * asynchronous pin and is seen as edges sampled on clk, so it must stay
 * well below half the system rate for every edge to be caught.
 */
// Contract
// - power-on reset loads defaults; both values then come from otp
// - pin held low: run from internal oscillator, trimmed to 12 MHz via otp
// - first rising edge on clock pin switches to external clock
// - 32 internal periods without external edge: fall back to internal
// - all timed functions count selected clock ticks, scaling with frequency
`timescale 1ns/1ps
module cssr_clock_select
    import cssr_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      resetn,
    // clock input pin of the driver
    input  wire logic      clk_pin,
    // otp read-out at power-up
    input  wire logic      otp_valid,
    input  wire logic [15:0] otp_word,
    // standstill indication from the step logic
    input  wire logic      standstill,
    // selected time base and its users
    output logic           tick_q,
    output logic [15:0]    tick_count_q,
    output logic           powerdown_q,
    // configuration and status
    output cssr_cfg_type   cfg_q,
    output cssr_status_type status_q
);

`include "cssr_map.svh"

    cssr_state_type state_q;
    logic [24:0]    acc_q;
    logic           osc_tick_q;
    logic [5:0]     timeout_q;
    logic [15:0]    still_q;
    logic           ext_rise;
    logic [24:0]    osc_inc;
    logic [25:0]    acc_sum;

    // pin filtering; the level is unused apart from the edge
    cssr_pin_sync u_pin_sync
    (
        .clk     (clk),
        .resetn  (resetn),
        .pin     (clk_pin),
        .level_q (),
        .rise_q  (ext_rise)
    );

    // trimmed oscillator increment, signed trim in coarse steps
    assign osc_inc = 25'(`CSSR_OSC_HZ + 25'($signed({{17{cfg_q.trim[7]}}, cfg_q.trim})
                     <<< `CSSR_TRIM_SHIFT));
    assign acc_sum = {1'b0, acc_q} + {1'b0, osc_inc};

    // internal oscillator model: fractional divider, one tick per period
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_q      <= 25'h000_0000;
            osc_tick_q <= 1'b0;
        end
        else if (acc_sum >= {1'b0, `CSSR_SYS_HZ})
        begin
            acc_q      <= 25'(acc_sum - {1'b0, `CSSR_SYS_HZ});
            osc_tick_q <= 1'b1;
        end
        else
        begin
            acc_q      <= acc_sum[24:0];
            osc_tick_q <= 1'b0;
        end
    end

    // configuration: constant defaults at reset, otp values once valid
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q.trim        <= `CSSR_DEF_TRIM;
            cfg_q.pwrdn_delay <= `CSSR_DEF_PWRDN;
        end
        else if (state_q == CSSR_LOAD && otp_valid)
        begin
            cfg_q.trim        <= otp_word[15:8];
            cfg_q.pwrdn_delay <= otp_word[7:0];
        end
    end

    // source selection state machine
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= CSSR_LOAD;
        end
        else
        begin
            case (state_q)
                CSSR_LOAD:
                begin
                    if (otp_valid)
                    begin
                        state_q <= CSSR_INT;
                    end
                end
                CSSR_INT:
                begin
                    if (ext_rise)
                    begin
                        state_q <= CSSR_EXT;
                    end
                end
                CSSR_EXT:
                begin
                    if (!ext_rise && osc_tick_q && timeout_q == `CSSR_EXT_TIMEOUT - 6'h01)
                    begin
                        state_q <= CSSR_INT;
                    end
                end
                default:
                begin
                    state_q <= CSSR_LOAD;
                end
            endcase
        end
    end

    // external timeout counted in internal periods, cleared by every edge
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timeout_q <= 6'h00;
        end
        else if (state_q != CSSR_EXT || ext_rise)
        begin
            timeout_q <= 6'h00;
        end
        else if (osc_tick_q)
        begin
            timeout_q <= timeout_q + 6'h01;
        end
    end

    // selected tick: whole periods only, one source per cycle, so a switch
    // can neither double a tick nor split one in half
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_q <= 1'b0;
        end
        else if (state_q == CSSR_EXT || (state_q == CSSR_INT && ext_rise))
        begin
            tick_q <= ext_rise;
        end
        else
        begin
            tick_q <= osc_tick_q;
        end
    end

    // free-running time base for chopper, blanking and step generator
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_count_q <= 16'h0000;
        end
        else if (tick_q)
        begin
            tick_count_q <= tick_count_q + 16'h0001;
        end
    end

    // standstill power-down delay measured in selected ticks
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            still_q     <= 16'h0000;
            powerdown_q <= 1'b0;
        end
        else if (!standstill)
        begin
            still_q     <= 16'h0000;
            powerdown_q <= 1'b0;
        end
        else if (tick_q && !powerdown_q)
        begin
            still_q     <= still_q + 16'h0001;
            powerdown_q <= (still_q + 16'h0001) >= ({8'h00, cfg_q.pwrdn_delay} << `CSSR_PWRDN_SHIFT);
        end
    end

    // status outputs; fail is a one-cycle pulse on fallback
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_q <= '0;
        end
        else
        begin
            status_q.ext_sel   <= (state_q == CSSR_EXT);
            status_q.cfg_ready <= (state_q != CSSR_LOAD);
            status_q.ext_fail  <= (state_q == CSSR_EXT) && !ext_rise && osc_tick_q
                                  && timeout_q == `CSSR_EXT_TIMEOUT - 6'h01;
        end
    end

endmodule

// ===== sim/cssr_clock_select_properties.sv
/*
 * port checker of the clock source selector.
 * assumes otp trim 0 and an external clock of at most 6 mhz.
 */
`timescale 1ns/1ps
`include "cssr_map.svh"
module cssr_clock_select_properties
    import cssr_pkg::*;
(
    // clock and reset
    input wire logic            clk,
    input wire logic            resetn,
    // watched ports
    input wire logic            clk_pin,
    input wire logic            otp_valid,
    input wire logic [15:0]     otp_word,
    input wire logic            standstill,
    input wire logic            tick_q,
    input wire logic            powerdown_q,
    input wire cssr_cfg_type    cfg_q,
    input wire cssr_status_type status_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [6:0] quiet_q;
    // cycles since the last pin rise, saturating so it never wraps
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            quiet_q <= 7'h00;
        else if ($rose(clk_pin))
            quiet_q <= 7'h00;
        else if (quiet_q != 7'h7f)
            quiet_q <= quiet_q + 7'h01;
    end
    // switch seen as a tick, then the select flag
    sequence s_switch;
        tick_q ##1 status_q.ext_sel;
    endsequence
    chk_cfg_default: assert property (!status_q.cfg_ready && !$past(otp_valid) |->
        cfg_q == {`CSSR_DEF_TRIM, `CSSR_DEF_PWRDN}) else $error("config not default");
    chk_otp_load: assert property ($rose(status_q.cfg_ready) |-> cfg_q == $past(otp_word))
        else $error("otp not loaded");
    // the divider needs four cycles to its first tick after reset, so wait for the otp load
    chk_int_runs: assert property (status_q.cfg_ready && !status_q.ext_sel |-> ##[0:3] tick_q)
        else $error("no internal tick");
    chk_pin_switch: assert property ($rose(clk_pin) && status_q.cfg_ready && !status_q.ext_sel
        |-> ##[2:5] s_switch) else $error("no switch");
    chk_ext_tick: assert property (status_q.ext_sel && $rose(clk_pin) |-> ##[2:5] tick_q)
        else $error("no external tick");
    chk_timeout_bound: assert property (status_q.ext_sel |-> quiet_q <= 7'h50)
        else $error("no fallback");
    chk_no_early: assert property ($fell(status_q.ext_sel) |-> quiet_q >= 7'h40)
        else $error("early fallback");
    // the fail pulse stands in the last cycle with the select flag still high
    chk_fail_pulse: assert property ($fell(status_q.ext_sel) |-> $past(status_q.ext_fail)
        && !status_q.ext_fail) else $error("bad fail pulse");
    chk_pd_release: assert property (!standstill |=> !powerdown_q) else $error("power-down held");
endmodule
bind cssr_clock_select cssr_clock_select_properties cssr_clock_select_properties_i (.clk(clk), .resetn(resetn),
    .clk_pin(clk_pin), .otp_valid(otp_valid), .otp_word(otp_word), .standstill(standstill), .tick_q(tick_q),
    .powerdown_q(powerdown_q), .cfg_q(cfg_q), .status_q(status_q));

// ===== sim/cssr_ext_clock_src.sv
/*
 * external clock source model driving the clock pin.
 * assumes the bench clock; pin stays low when stopped or in reset.
 */
`timescale 1ns/1ps
module cssr_ext_clock_src
(
    // bench clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // control
    input  wire logic       run,
    input  wire logic [3:0] half_cycles,
    // clock pin
    output logic            pin
);
    logic [3:0] cnt_q;
    // square wave; slow since the selector samples the pin on clk
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin   <= 1'b0;
            cnt_q <= 4'h1;
        end
        else if (!run)
        begin
            pin   <= 1'b0;
            cnt_q <= 4'h1;
        end
        else if (cnt_q >= half_cycles)
        begin
            pin   <= ~pin;
            cnt_q <= 4'h1;
        end
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule

// ===== sim/cssr_clock_select_tb_top.sv
/*
 * bench of the clock source selector.
 * assumes the selector, its checker and the source model.
 */
`timescale 1ns/1ps
`include "cssr_map.svh"
module cssr_clock_select_tb_top
    import cssr_pkg::*;
;
    logic            clk = 1'b0;
    logic            resetn = 1'b0;
    logic            otp_valid = 1'b0;
    logic            standstill = 1'b0;
    logic            run = 1'b0;
    logic            fail_seen = 1'b0;
    logic            clk_pin;
    logic            tick_q;
    logic            powerdown_q;
    logic [15:0]     tick_count_q;
    logic [15:0]     c0;
    logic [15:0]     r0;
    logic [15:0]     rises = 16'h0000;
    cssr_cfg_type    cfg_q;
    cssr_status_type status_q;
    int              error_cnt = 0;
    int              samples_checked = 0;
    int              n;
    always #20 clk = ~clk;
    // pin rises and fail pulses as the bench sees them
    always @(posedge clk_pin) rises <= rises + 16'h0001;
    always @(posedge clk) if (status_q.ext_fail === 1'b1) fail_seen <= 1'b1;
    cssr_ext_clock_src cssr_ext_clock_src_i (.clk(clk), .resetn(resetn), .run(run), .half_cycles(4'h3),
        .pin(clk_pin));
    cssr_clock_select cssr_clock_select_i (.clk(clk), .resetn(resetn), .clk_pin(clk_pin),
        .otp_valid(otp_valid), .otp_word(16'h0001), .standstill(standstill), .tick_q(tick_q),
        .tick_count_q(tick_count_q), .powerdown_q(powerdown_q), .cfg_q(cfg_q), .status_q(status_q));
    task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_sel(input logic want, input int limit);
        n = 0;
        while (status_q.ext_sel !== want)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > limit)
            begin
                cmp(16'(status_q.ext_sel), 16'(want));
                results();
            end
        end
    endtask
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        otp_valid <= 1'b0;
        standstill <= 1'b0;
        run <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        cmp(cfg_q, {`CSSR_DEF_TRIM, `CSSR_DEF_PWRDN});
        cmp(16'(status_q), 16'h0000);
        @(posedge clk);
        resetn <= 1'b1;
    endtask
    task automatic t_load();
        repeat (4) @(posedge clk);
        otp_valid <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        cmp(cfg_q, 16'h0001);
        cmp(16'(status_q.cfg_ready), 16'h0001);
    endtask
    // 250 cycles at 12 of 25 is exactly 120 ticks
    task automatic t_rate();
        c0 = tick_count_q;
        repeat (250) @(posedge clk);
        #1;
        cmp(tick_count_q - c0, 16'h0078);
    endtask
    task automatic t_ext();
        @(posedge clk);
        run <= 1'b1;
        wait_sel(1'b1, 20);
        cmp(16'(n <= 10), 16'h0001);
        // a pin rise reaches the tick count six cycles later: take the rise count that much earlier
        r0 = rises;
        repeat (6) @(posedge clk);
        #1;
        c0 = tick_count_q;
        repeat (114) @(posedge clk);
        #1;
        cmp(16'(status_q.ext_sel), 16'h0001);
        @(posedge clk);
        run <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        cmp(tick_count_q - c0, rises - r0);
        wait_sel(1'b0, 100);
        cmp(16'(n >= 40), 16'h0001);
        repeat (2) @(posedge clk);
        cmp(16'(fail_seen), 16'h0001);
    endtask
    task automatic t_pd();
        @(posedge clk);
        standstill <= 1'b1;
        #1;
        c0 = tick_count_q;
        for (n = 0; n < 700 && powerdown_q !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        cmp(16'(powerdown_q), 16'h0001);
        if (powerdown_q !== 1'b1)
        begin
            results();
        end
        cmp(16'(tick_count_q - c0 >= 16'h0100 && tick_count_q - c0 <= 16'h0101), 16'h0001);
        @(posedge clk);
        standstill <= 1'b0;
        @(posedge clk);
        #1;
        cmp(16'(powerdown_q), 16'h0000);
    endtask
    // main sequence, ending with a reset in mid-run
    initial
    begin
        do_reset();
        t_load();
        t_rate();
        t_ext();
        t_pd();
        @(posedge clk);
        run <= 1'b1;
        wait_sel(1'b1, 20);
        do_reset();
        // two edges after release the block still waits for otp with defaults
        repeat (2) @(posedge clk);
        #1;
        cmp(16'(status_q), 16'h0000);
        cmp(cfg_q, {`CSSR_DEF_TRIM, `CSSR_DEF_PWRDN});
        results();
    end
endmodule
